// file: hw/lmsc_top.sv
// Serial command front end and scan control of a 16 by 8 LED driver.
`include "lmsc_defs.svh"

module lmsc_top
  import lmsc_pkg::*;
#(
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset.
  input  wire logic                  mclk_in,
  input  wire logic                  sys_rst_in,
  // Three-wire link; data line is input only, its output and enable tied low.
  input  wire logic                  frame_select_in,
  input  wire logic                  link_clk_in,
  input  wire logic                  serial_data_line_in,
  output logic                       serial_data_line_out,
  output logic                       serial_data_line_oe_out,
  // LED drive, active high: segment on, position selected.
  output logic [15:0]                segment_outputs_out,
  output logic [7:0]                 position_outputs_out,
  // Status.
  output lmsc_pkg::lmsc_disp_s       disp_state_out,
  output logic [4:0]                 pointer_out
);
  import lmsc_pkg::*;

  // =====================================================================
  // Power-on reset: held internally for a few cycles after configuration.
  logic [4:0] por_cnt_q = 5'h00;
  logic       por_q     = 1'b1;
  wire        rst       = sys_rst_in || por_q;

  // The counter starts from its initial value, so no external pin needed.
  always_ff @(posedge mclk_in) begin
    if (por_cnt_q != 5'(`LMSC_POR_CYCLES)) por_cnt_q <= por_cnt_q + 5'h01;
    por_q <= (por_cnt_q != 5'(`LMSC_POR_CYCLES));
  end

  // =====================================================================
  // Link edge detection; inputs are synchronous to mclk.
  logic stb_q;
  logic lclk_q;
  wire  stb_edge  = stb_q != frame_select_in;
  wire  lclk_rise = link_clk_in && !lclk_q && !frame_select_in;

  always_ff @(posedge mclk_in) begin
    if (rst) begin
      stb_q  <= 1'b1;
      lclk_q <= 1'b0;
    end else begin
      stb_q  <= frame_select_in;
      lclk_q <= link_clk_in;
    end
  end

  // =====================================================================
  // Byte shifter: bits enter from the top, so bit 0 arrives first.
  logic [7:0] sh_q;
  logic [2:0] bit_q;
  logic       first_q;
  wire        byte_done = lclk_rise && (bit_q == 3'h7);
  wire [7:0]  byte_val  = {serial_data_line_in, sh_q[7:1]};
  logic       fifo_rdy;

  // Select edges clear the bit count, dropping a partial byte.
  always_ff @(posedge mclk_in) begin
    if (rst || stb_edge) begin
      bit_q   <= 3'h0;
      sh_q    <= 8'h00;
      first_q <= 1'b1;
    end else if (lclk_rise) begin
      sh_q  <= byte_val;
      bit_q <= bit_q + 3'h1;
      if (byte_done && fifo_rdy) first_q <= 1'b0;
    end
  end

  // =====================================================================
  // Byte FIFO between shifter and decoder. A byte met by a full FIFO is
  // lost; at 20 MHz the decoder drains far faster than any link rate.
  lmsc_byte_s in_byte;
  lmsc_byte_s out_byte;
  logic       out_vld;
  logic [8:0] out_raw;
  assign in_byte  = '{first: first_q, data: byte_val};
  assign out_byte = lmsc_byte_s'(out_raw);

  lmsc_fifo #(
    .WIDTH (9),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk_in      (mclk_in),
    .sys_rst_in   (rst),
    .wr_valid_in  (byte_done && !stb_edge),
    .wr_ready_out (fifo_rdy),
    .wr_data_in   (in_byte),
    .rd_valid_out (out_vld),
    .rd_ready_in  (1'b1),
    .rd_data_out  (out_raw)
  );

  // =====================================================================
  // Command decode.
  lmsc_state_e st_q;
  logic [4:0]  ptr_q;
  logic        fixed_q;
  lmsc_disp_s  pend_q;
  lmsc_disp_s  act_q;
  logic [7:0]  dmem_q [16];
  wire  [7:0]  b        = out_byte.data;
  wire  [1:0]  ctype    = b[7:6];
  wire         is_cmd   = out_vld && (out_byte.first || st_q != LMSC_DATA);
  wire         is_data  = out_vld && !is_cmd;
  wire         ptr_ok   = !ptr_q[4];
  wire         wr_mem   = is_data && ptr_ok;

  // An address command moves into data reception; a frame's first byte is always a command.
  always_ff @(posedge mclk_in) begin
    if (rst) begin
      st_q    <= LMSC_IDLE;
      ptr_q   <= `LMSC_PTR_RST;
      fixed_q <= 1'b0;
      pend_q  <= '{on: 1'b0, dim: `LMSC_DIM_RST};
    end else if (is_cmd) begin
      unique case (ctype)
        `LMSC_CMD_DATA: begin
          fixed_q <= b[`LMSC_MODE_BIT];
          st_q    <= LMSC_CMD;
        end
        `LMSC_CMD_ADDR: begin
          ptr_q <= {1'b0, b[3:0]};
          st_q  <= LMSC_DATA;
        end
        `LMSC_CMD_DISP: begin
          pend_q <= '{on: b[`LMSC_ON_BIT], dim: b[2:0]};
          st_q   <= LMSC_CMD;
        end
        default: st_q <= LMSC_CMD;
      endcase
    end else if (is_data) begin
      // Auto mode steps on; fixed mode keeps the last address.
      if (!fixed_q && ptr_ok) ptr_q <= ptr_q + 5'h01;
      if (fixed_q) st_q <= LMSC_CMD;
    end
  end

  // Display memory write.
  always_ff @(posedge mclk_in) begin
    if (wr_mem) dmem_q[ptr_q[3:0]] <= b;
  end

  // =====================================================================
  // Scan timing: a tick every 45 clocks (about 444 kHz), 16 slots per position period.
  localparam int DIV = `LMSC_OSC_DIV;
  logic [$clog2(DIV)-1:0] div_q;
  logic [3:0]             slot_q;
  logic [2:0]             pos_q;
  wire                    tick     = (div_q == ($clog2(DIV))'(DIV - 1));
  wire                    boundary = tick && (slot_q == 4'hF);

  always_ff @(posedge mclk_in) begin
    if (rst) begin
      div_q  <= '0;
      slot_q <= 4'h0;
      pos_q  <= 3'h0;
      act_q  <= '{on: 1'b0, dim: `LMSC_DIM_RST};
    end else begin
      div_q <= tick ? '0 : div_q + 1'b1;
      if (tick) slot_q <= slot_q + 4'h1;
      if (boundary) begin
        pos_q <= pos_q + 3'h1;
        act_q <= pend_q;
      end
    end
  end

  // Pulse width in slots for each brightness code.
  logic [4:0] width;
  always_comb begin
    unique case (act_q.dim)
      3'h0: width = 5'h01;
      3'h1: width = 5'h02;
      3'h2: width = 5'h04;
      3'h3: width = 5'h0A;
      3'h4: width = 5'h0B;
      3'h5: width = 5'h0C;
      3'h6: width = 5'h0D;
      3'h7: width = 5'h0E;
    endcase
  end

  // Lit slot window and segment pattern for the current position.
  wire        lit  = act_q.on && ({1'b0, slot_q} < width);
  wire [15:0] segs = {dmem_q[{pos_q, 1'b1}], dmem_q[{pos_q, 1'b0}]};

  // =====================================================================
  // Registered outputs.
  logic [15:0] seg_q;
  logic [7:0]  grid_q;
  always_ff @(posedge mclk_in) begin
    if (rst) begin
      seg_q  <= 16'h0000;
      grid_q <= 8'h00;
    end else begin
      seg_q  <= lit ? segs : 16'h0000;
      grid_q <= lit ? (8'h01 << pos_q) : 8'h00;
    end
  end

  assign segment_outputs_out     = seg_q;
  assign position_outputs_out    = grid_q;
  assign serial_data_line_out    = 1'b0;
  assign serial_data_line_oe_out = 1'b0;
  assign disp_state_out          = act_q;
  assign pointer_out             = ptr_q;
endmodule

// file: hw/lmsc_defs.svh
// Constant definitions for the LED matrix serial command unit.
`ifndef LMSC_DEFS_SVH
`define LMSC_DEFS_SVH
// =====================================================================
// Command decode
`define LMSC_CMD_DATA      2'h1
`define LMSC_CMD_DISP      2'h2
`define LMSC_CMD_ADDR      2'h3
`define LMSC_MODE_BIT      2
`define LMSC_ON_BIT        3
// =====================================================================
// Reset values
`define LMSC_PTR_RST       5'h00
`define LMSC_DIM_RST       3'h0
// =====================================================================
// Timing
`define LMSC_CLK_HZ        20000000
`define LMSC_OSC_HZ        450000
`define LMSC_OSC_DIV       ((`LMSC_CLK_HZ + `LMSC_OSC_HZ - 1) / `LMSC_OSC_HZ)
`define LMSC_SLOTS         16
`define LMSC_POR_CYCLES    16
`endif

// file: hw/lmsc_pkg.sv
// Types shared by the LED matrix serial command unit.
package lmsc_pkg;
  // =====================================================================
  // Receiver states.
  typedef enum logic [1:0] {
    LMSC_IDLE,
    LMSC_CMD,
    LMSC_DATA
  } lmsc_state_e;

  // Display settings that travel together to the scan logic.
  typedef struct packed {
    logic       on;
    logic [2:0] dim;
  } lmsc_disp_s;

  // A received byte and whether it is the frame's first.
  typedef struct packed {
    logic       first;
    logic [7:0] data;
  } lmsc_byte_s;
endpackage

// file: hw/lmsc_fifo.sv
// Small synchronous FIFO with valid and ready on both sides.
module lmsc_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  // Clock and reset.
  input  wire logic             mclk_in,
  input  wire logic             sys_rst_in,
  // Fill side.
  input  wire logic             wr_valid_in,
  output logic                  wr_ready_out,
  input  wire logic [WIDTH-1:0] wr_data_in,
  // Drain side.
  output logic                  rd_valid_out,
  input  wire logic             rd_ready_in,
  output logic      [WIDTH-1:0] rd_data_out
);
  localparam int AW = $clog2(DEPTH);

  // =====================================================================
  // Storage and pointers.
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wp_q;
  logic [AW-1:0]    rp_q;
  logic [AW:0]      cnt_q;
  wire              push = wr_valid_in && wr_ready_out;
  wire              pop  = rd_valid_out && rd_ready_in;

  // Full and empty come from the occupancy count.
  // The full mark is sized to the count, since DEPTH does not fit in AW bits.
  assign wr_ready_out = (cnt_q != (AW + 1)'(DEPTH)) ? 1'b1 : 1'b0;
  assign rd_valid_out = (cnt_q != '0);
  assign rd_data_out  = mem_q[rp_q];

  // Pointer and count update.
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wp_q <= AW'((wp_q + 1'b1) % DEPTH);
      if (pop) rp_q <= AW'((rp_q + 1'b1) % DEPTH);
      cnt_q <= cnt_q + {AW'(0), push} - {AW'(0), pop};
    end
  end

  // Storage write; memory has no reset.
  always_ff @(posedge mclk_in) begin
    if (push) mem_q[wp_q] <= wr_data_in;
  end
endmodule

// file: tb/lmsc_checker_assertions.sv
// Port assertions for the LED matrix serial command unit.
module lmsc_checker
  import lmsc_pkg::*;
#(
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset.
  input  wire logic                 mclk_in,
  input  wire logic                 sys_rst_in,
  // Link and drive outputs.
  input  wire logic                 frame_select_in,
  input  wire logic                 serial_data_line_oe_out,
  input  wire logic [15:0]          segment_outputs_out,
  input  wire logic [7:0]           position_outputs_out,
  input  wire lmsc_pkg::lmsc_disp_s disp_state_out,
  input  wire logic [4:0]           pointer_out
);
  // ==================================================================
  // Checks; the reset cases turn the default disable off.
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);
  AST_OE_LOW: assert property (!serial_data_line_oe_out)
    else $error("data line driven by a write-only unit");
  AST_POS_ONEHOT: assert property ($onehot0(position_outputs_out))
    else $error("more than one position selected");
  AST_SEG_IDLE: assert property (position_outputs_out == 8'h00
    |-> segment_outputs_out == 16'h0000)
    else $error("segments lit with no position");
  AST_BLANK: assert property (!disp_state_out.on
    && !$past(disp_state_out.on) |-> segment_outputs_out == 16'h0000)
    else $error("segments lit while display off");
  AST_RST_PTR: assert property (disable iff (1'b0)
    sys_rst_in |=> pointer_out == 5'h00)
    else $error("pointer not cleared by reset");
  AST_RST_DISP: assert property (disable iff (1'b0)
    sys_rst_in |=> disp_state_out == 4'h0)
    else $error("display settings not cleared by reset");
  AST_SEL_HIGH: assert property (frame_select_in [*5]
    |-> $stable(pointer_out))
    else $error("pointer moved while select high");
  AST_PTR_MAX: assert property (pointer_out <= 5'h10)
    else $error("pointer beyond discard value");
endmodule

bind lmsc_top lmsc_checker #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (
  .mclk_in(mclk_in),
  .sys_rst_in(sys_rst_in),
  .frame_select_in(frame_select_in),
  .serial_data_line_oe_out(serial_data_line_oe_out),
  .segment_outputs_out(segment_outputs_out),
  .position_outputs_out(position_outputs_out),
  .disp_state_out(disp_state_out),
  .pointer_out(pointer_out)
);

// file: tb/lmsc_host_model.sv
// Behavioural host that drives the three-wire link.
module lmsc_host_model (
  // Bench clock.
  input  wire logic mclk_in,
  // Link lines toward the unit.
  output logic      frame_select_out,
  output logic      link_clk_out,
  output logic      data_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==================================================================
  // Idle levels at time zero.
  initial begin
    frame_select_out = 1'b1;
    link_clk_out     = 1'b0;
    data_out         = 1'b1;
  end
  // Clock is parked low before select falls.
  task automatic open_frame();
    @(posedge mclk_in);
    link_clk_out <= 1'b0;
    repeat (2) @(posedge mclk_in);
    frame_select_out <= 1'b0;
    repeat (2) @(posedge mclk_in);
  endtask
  // Data moves only while the clock is low, so each rise sees it settled.
  task automatic send_bits(input logic [7:0] b, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge mclk_in);
      link_clk_out <= 1'b0;
      data_out     <= b[i];
      repeat (2) @(posedge mclk_in);
      link_clk_out <= 1'b1;
      @(posedge mclk_in);
    end
  endtask
  // Released data flips so a stale bit can never pass for a real one.
  task automatic close_frame();
    @(posedge mclk_in);
    link_clk_out <= 1'b0;
    repeat (2) @(posedge mclk_in);
    frame_select_out <= 1'b1;
    data_out         <= ~data_out;
  endtask
endmodule

// file: tb/tb_top.sv
// Self-checking testbench for the LED matrix serial command unit.
`include "lmsc_defs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic                 mclk = 1'b0;
  logic                 sys_rst = 1'b1;
  logic                 sel, lclk, sdata, d_out, d_oe;
  logic [15:0]          seg;
  logic [7:0]           pos;
  logic [4:0]           ptr;
  lmsc_pkg::lmsc_disp_s disp;
  int                   failures = 0;
  int                   samples_checked = 0;

  always #25 mclk = ~mclk;

  lmsc_host_model u_host (.mclk_in(mclk), .frame_select_out(sel),
    .link_clk_out(lclk), .data_out(sdata));
  lmsc_top #(.FIFO_DEPTH(8)) uut (.mclk_in(mclk), .sys_rst_in(sys_rst),
    .frame_select_in(sel), .link_clk_in(lclk),
    .serial_data_line_in(sdata), .serial_data_line_out(d_out),
    .serial_data_line_oe_out(d_oe), .segment_outputs_out(seg),
    .position_outputs_out(pos), .disp_state_out(disp),
    .pointer_out(ptr));
  // ==================================================================
  // Shared helpers.
  task automatic chk(input string what, input logic [31:0] exp, got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic frame(input logic [7:0] b [$]);
    u_host.open_frame();
    foreach (b[i]) u_host.send_bits(b[i], 8);
    u_host.close_frame();
    repeat (8) @(posedge mclk);
  endtask
  // Settings only land at a scan boundary, so the wait is bounded.
  task automatic wait_disp(input logic [3:0] exp);
    for (int n = 0; n < 1500 && disp !== exp; n++) @(posedge mclk);
    chk("display state", {28'h0, exp}, {28'h0, disp});
  endtask
  // Lit cycles over one position period; the lit window repeats per period.
  task automatic count_lit(input string what, input int exp);
    int lit_cnt;
    lit_cnt = 0;
    repeat (`LMSC_SLOTS * `LMSC_OSC_DIV) begin
      @(posedge mclk);
      if (pos !== 8'h00) lit_cnt++;
    end
    chk(what, 32'(exp), 32'(lit_cnt));
  endtask
  task automatic conclude();
    $display("Checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ==================================================================
  // Scenarios.
  task automatic t_links();
    u_host.send_bits(8'hC5, 8);
    repeat (8) @(posedge mclk);
    chk("pointer select high", 32'h0, {27'h0, ptr});
    frame('{8'h40, 8'hC0, 8'h3F, 8'hA5, 8'h11});
    chk("pointer auto", 32'h3, {27'h0, ptr});
    u_host.open_frame();
    u_host.send_bits(8'hC7, 8);
    u_host.send_bits(8'hC2, 4);
    u_host.close_frame();
    repeat (8) @(posedge mclk);
    chk("pointer partial", 32'h7, {27'h0, ptr});
    frame('{8'hC2});
    chk("pointer new frame", 32'h2, {27'h0, ptr});
    frame('{8'h40, 8'hCF, 8'h00, 8'h00, 8'h00});
    chk("pointer limit", 32'h10, {27'h0, ptr});
    frame('{8'hC4});
    chk("pointer load", 32'h4, {27'h0, ptr});
    frame('{8'h03});
    chk("pointer unknown type", 32'h4, {27'h0, ptr});
    frame('{8'h44, 8'hC5, 8'h77});
    chk("pointer fixed", 32'h5, {27'h0, ptr});
    frame('{8'h44, 8'hC5, 8'h77, 8'hC6, 8'h88});
    chk("pointer fixed pair", 32'h6, {27'h0, ptr});
  endtask
  task automatic t_display();
    int widths [8] = '{1, 2, 4, 10, 11, 12, 13, 14};
    frame('{8'h87});
    wait_disp(4'h7);
    count_lit("lit cycles blank", 0);
    for (int c = 0; c < 8; c++) begin
      frame('{8'h88 | 8'(c)});
      wait_disp({1'b1, 3'(c)});
      count_lit("lit cycles", widths[c] * `LMSC_OSC_DIV);
    end
    for (int n = 0; n < 8000 && !(pos === 8'h01 && seg !== 16'h0); n++)
      @(posedge mclk);
    chk("position one segments", 32'hA53F, {16'h0, seg});
  endtask
  // ==================================================================
  // Main sequence and watchdog.
  initial begin
    repeat (12) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (20) @(posedge mclk);
    chk("pointer after reset", 32'h0, {27'h0, ptr});
    chk("display after reset", 32'h0, {28'h0, disp});
    chk("data line drive", 32'h0, {30'h0, d_oe, d_out});
    t_links();
    t_display();
    conclude();
  end
  initial begin
    repeat (40000) @(posedge mclk);
    failures++;
    conclude();
  end
endmodule
